// *** verilog/qwri_slave.sv ***
// qwri_slave: serial-bus slave holding four 8-bit wiper position registers.
// assumes: scl/sda arrive unsynchronised; link_clk oversamples the bus well above
// the serial clock; wiper_tap is consumed on clk; an external open-drain pad
// pulls sda low while sda_drive_n is low.
`timescale 1ns/100ps

// Behaviour
// R1: each potentiometer has an 8-bit volatile wiper register whose value alone sets its tap.
// R2: there are four wiper registers, each written and read without touching the others.
// R3: a register value of all zeroes selects the tap nearest the low terminal.
// R4: a register value of all ones selects the tap nearest the high terminal.
// R5: rising codes from 0 to 255 move the tap monotonically, one tap per code step.
// R6: after power-up every wiper register holds mid-scale, 128.
// R7: address bytes zero to three select wiper registers zero to three for reads and writes.
// R8: the device is only a slave; it never starts a transfer nor drives the serial clock.
// R9: the master starts every transfer and supplies the serial clock in both directions.
// R10: every byte on the bus travels most significant bit first.
// R11: the identification byte is 0101, three select bits matching the straps, then read/write.
// R12: a write is start, id, address, one data byte, stop; each byte is acked, then standby.
// R13: a read is start, id write, address, repeated start, id read, then data until a nack.
// R14: the read pointer starts at the address, steps after each data byte and wraps 3 to 0.
// R15: an address byte above three is not acked and leaves every wiper register unchanged.
module qwri_slave (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic link_clk,
    input wire logic scl,
    input wire logic sda_in,
    input wire qwri_pkg::qwri_dev_sel_t dev_select,
    output logic sda_out,
    output logic sda_drive_n,
    output qwri_pkg::qwri_wiper_bank_t wiper_tap
);
    import qwri_pkg::*;

    // link-domain reset, asserted at once, released on link_clk
    logic [1:0] link_rst_sync_reg;
    logic link_rst_n;
    // bus and strap synchronisers
    logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
    logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
    qwri_dev_sel_t sel_meta_reg, sel_sync_reg;
    logic scl_rise, scl_fall, start_seen, stop_seen, byte_done, id_ok;
    // protocol state
    qwri_state_t state_reg, ack_next_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic [PTR_W-1:0] ptr_reg;
    logic master_ack_reg;
    logic sda_drive_n_reg;
    // crossing handshakes
    logic wr_tgl_reg;
    qwri_wr_req_t wr_req_reg;
    logic rd_tgl_reg;
    logic rd_ack_meta_reg, rd_ack_sync_reg;
    logic rd_ready;
    logic wr_tgl_meta_reg, wr_tgl_sync_reg, wr_tgl_prev_reg;
    logic rd_tgl_meta_reg, rd_tgl_sync_reg, rd_tgl_prev_reg;
    logic wr_seen, rd_seen;
    logic [7:0] rd_word_reg;
    logic rd_ack_tgl_reg;
    qwri_wiper_bank_t wiper_bank_reg;
    logic boot_reg;

    // link reset release; the data input is a constant, not a port
    always_ff @(posedge link_clk or negedge arst_n) begin
        if (!arst_n) begin
            link_rst_sync_reg <= 2'h0;
        end else begin
            link_rst_sync_reg <= {link_rst_sync_reg[0], 1'b1};
        end
    end
    assign link_rst_n = link_rst_sync_reg[1];

    // two-stage synchronisers; bus lines idle high
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            sel_meta_reg <= '0;
            sel_sync_reg <= '0;
            rd_ack_meta_reg <= 1'b0;
            rd_ack_sync_reg <= 1'b0;
        end else begin
            scl_meta_reg <= scl;
            scl_sync_reg <= scl_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_meta_reg <= sda_in;
            sda_sync_reg <= sda_meta_reg;
            sda_prev_reg <= sda_sync_reg;
            sel_meta_reg <= dev_select;
            sel_sync_reg <= sel_meta_reg;
            rd_ack_meta_reg <= rd_ack_tgl_reg;
            rd_ack_sync_reg <= rd_ack_meta_reg;
        end
    end

    // bus events; start and stop are sda edges while scl stays high [R9]
    assign scl_rise = scl_sync_reg && !scl_prev_reg;
    assign scl_fall = !scl_sync_reg && scl_prev_reg;
    assign start_seen = scl_sync_reg && scl_prev_reg && sda_prev_reg && !sda_sync_reg;
    assign stop_seen = scl_sync_reg && scl_prev_reg && !sda_prev_reg && sda_sync_reg;
    assign byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
    // identification match against the straps [R11]
    assign id_ok = (shift_reg[7:ID_PREFIX_LSB] == ID_PREFIX)
        && (shift_reg[ID_PREFIX_LSB-1:ID_SEL_LSB] == sel_sync_reg);
    // the read answer is valid once the acknowledge toggle has caught up
    assign rd_ready = (rd_ack_sync_reg == rd_tgl_reg);

    // protocol engine; start restarts from any state, stop returns to standby
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_reg <= st_idle;
            ack_next_reg <= st_idle;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            tx_reg <= TX_IDLE;
            ptr_reg <= '0;
            master_ack_reg <= 1'b0;
            wr_tgl_reg <= 1'b0;
            wr_req_reg <= '0;
            rd_tgl_reg <= 1'b0;
        end else if (start_seen) begin
            state_reg <= st_id;
            bit_cnt_reg <= 4'h0;
        end else if (stop_seen) begin
            state_reg <= st_idle; // [R12]
        end else begin
            unique case (state_reg)
                st_idle, st_wait: begin
                    bit_cnt_reg <= 4'h0;
                end
                st_id, st_addr, st_wdata: begin
                    if (scl_rise) begin
                        // shift in at the low end, so the first bit ends at the top [R10]
                        shift_reg <= {shift_reg[6:0], sda_sync_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_reg <= 4'h0;
                        if (state_reg == st_id) begin
                            if (!id_ok) begin
                                state_reg <= st_wait; // [R11]
                            end else if (shift_reg[ID_RW_BIT] == RW_READ) begin
                                // fetch early: the ack bit gives the crossing time [R13]
                                state_reg <= st_ack;
                                ack_next_reg <= st_tx;
                                rd_tgl_reg <= ~rd_tgl_reg;
                            end else begin
                                state_reg <= st_ack;
                                ack_next_reg <= st_addr;
                            end
                        end else if (state_reg == st_addr) begin
                            if (shift_reg[7:PTR_W] == '0) begin
                                ptr_reg <= shift_reg[PTR_W-1:0]; // [R7] [R14]
                                state_reg <= st_ack;
                                ack_next_reg <= st_wdata;
                            end else begin
                                state_reg <= st_wait; // [R15]
                            end
                        end else begin
                            // one data byte per write, then standby [R12]
                            wr_req_reg <= '{addr: ptr_reg, data: shift_reg};
                            wr_tgl_reg <= ~wr_tgl_reg;
                            state_reg <= st_ack;
                            ack_next_reg <= st_wait;
                        end
                    end
                end
                st_ack: begin
                    if (scl_fall) begin
                        state_reg <= ack_next_reg;
                        if (ack_next_reg == st_tx) begin
                            tx_reg <= rd_ready ? rd_word_reg : TX_IDLE;
                        end
                    end
                end
                st_tx: begin
                    if (scl_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b1}; // [R10]
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == TX_LAST_BIT) begin
                            // step the pointer, 2 bits wide so 3 wraps to 0 [R14]
                            ptr_reg <= ptr_reg + PTR_W'(1);
                            rd_tgl_reg <= ~rd_tgl_reg;
                            bit_cnt_reg <= 4'h0;
                            state_reg <= st_tx_ack;
                        end
                    end
                end
                st_tx_ack: begin
                    if (scl_rise) begin
                        master_ack_reg <= !sda_sync_reg;
                    end else if (scl_fall) begin
                        if (master_ack_reg) begin
                            tx_reg <= rd_ready ? rd_word_reg : TX_IDLE; // [R13]
                            state_reg <= st_tx;
                        end else begin
                            state_reg <= st_wait; // [R13]
                        end
                    end
                end
                default: begin
                    state_reg <= st_idle;
                end
            endcase
        end
    end

    // sda pull-down, registered; only sda is ever driven, never scl [R8]
    always_ff @(posedge link_clk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sda_drive_n_reg <= 1'b1;
        end else begin
            sda_drive_n_reg <= !((state_reg == st_ack)
                || ((state_reg == st_tx) && !tx_reg[7])); // [R10] [R12]
        end
    end
    assign sda_drive_n = sda_drive_n_reg;
    assign sda_out = 1'b0;

    // system-side synchronisers for the two request toggles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_tgl_meta_reg <= 1'b0;
            wr_tgl_sync_reg <= 1'b0;
            wr_tgl_prev_reg <= 1'b0;
            rd_tgl_meta_reg <= 1'b0;
            rd_tgl_sync_reg <= 1'b0;
            rd_tgl_prev_reg <= 1'b0;
            boot_reg <= 1'b1;
        end else begin
            wr_tgl_meta_reg <= wr_tgl_reg;
            wr_tgl_sync_reg <= wr_tgl_meta_reg;
            wr_tgl_prev_reg <= wr_tgl_sync_reg;
            rd_tgl_meta_reg <= rd_tgl_reg;
            rd_tgl_sync_reg <= rd_tgl_meta_reg;
            rd_tgl_prev_reg <= rd_tgl_sync_reg;
            boot_reg <= 1'b0;
        end
    end
    assign wr_seen = wr_tgl_sync_reg ^ wr_tgl_prev_reg;
    assign rd_seen = rd_tgl_sync_reg ^ rd_tgl_prev_reg;

    // wiper registers; the request word is stable while its toggle crosses [R2] [R6]
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wiper_bank_reg <= {NUM_WIPERS{WIPER_RESET}};
        end else if (wr_seen) begin
            wiper_bank_reg[wr_req_reg.addr] <= wr_req_reg.data; // [R7]
        end
    end

    // read answer; ptr_reg holds still until the next byte ends
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_word_reg <= 8'h00;
            rd_ack_tgl_reg <= 1'b0;
        end else if (rd_seen) begin
            rd_word_reg <= wiper_bank_reg[ptr_reg]; // [R7] [R14]
            rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
        end
    end

    // plain binary code is the tap number: 00 at low end, ff at high end [R1] [R3] [R4] [R5]
    assign wiper_tap = wiper_bank_reg;

    // single-cycle sequences used by the checks below
    sequence s_id_end;
        (state_reg == st_id) && byte_done && !start_seen && !stop_seen;
    endsequence
    sequence s_addr_end;
        (state_reg == st_addr) && byte_done && !start_seen && !stop_seen;
    endsequence
    sequence s_tx_last;
        (state_reg == st_tx) && scl_fall && (bit_cnt_reg == TX_LAST_BIT)
            && !start_seen && !stop_seen;
    endsequence

    chk_reset_midscale: assert property (@(posedge clk) disable iff (!arst_n) // [R6]
        boot_reg |-> (wiper_bank_reg == {NUM_WIPERS{WIPER_RESET}}))
        else $error("wiper registers not mid-scale after reset");

    chk_write_lands: assert property (@(posedge clk) disable iff (!arst_n) // [R7]
        wr_seen |=> (wiper_bank_reg[$past(wr_req_reg.addr)] == $past(wr_req_reg.data)))
        else $error("write did not reach the addressed wiper");

    chk_bank_idle: assert property (@(posedge clk) disable iff (!arst_n) // [R2]
        !wr_seen |=> $stable(wiper_bank_reg))
        else $error("wiper register changed without a write");

    chk_read_word: assert property (@(posedge clk) disable iff (!arst_n) // [R14]
        rd_seen |=> (rd_word_reg == $past(wiper_bank_reg[ptr_reg])))
        else $error("read answer differs from the pointed wiper");

    chk_id_reject: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [R11]
        (s_id_end ##0 !id_ok) |=> (state_reg == st_wait) ##1 sda_drive_n[*2])
        else $error("mismatched identification byte was acknowledged");

    chk_addr_reject: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [R15]
        (s_addr_end ##0 (shift_reg[7:PTR_W] != '0)) |=> (state_reg == st_wait))
        else $error("out of range address byte was acknowledged");

    chk_ptr_wrap: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [R14]
        s_tx_last |=> (ptr_reg == $past(ptr_reg) + 2'h1) && (state_reg == st_tx_ack))
        else $error("read pointer did not step after a data byte");

    chk_ack_drive: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [R12]
        (state_reg == st_ack) |=> !sda_drive_n)
        else $error("acknowledge bit not pulled low");

    chk_drive_only: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [R8]
        !sda_drive_n |-> ($past(state_reg) == st_ack) || ($past(state_reg) == st_tx))
        else $error("sda pulled low outside acknowledge or transmit");

    chk_msb_first: assert property (@(posedge link_clk) disable iff (!link_rst_n) // [R10]
        ((state_reg == st_ack) && (ack_next_reg == st_tx) && scl_fall && rd_ready
            && !start_seen && !stop_seen)
            |=> ##1 (sda_drive_n == $past(rd_word_reg[7], 2)))
        else $error("first transmitted bit is not the top bit");

endmodule

// *** verilog/qwri_pkg.sv ***
// qwri_pkg: constants, carriers and state codes for the quad wiper register serial slave.
// assumes: shared by the slave module and the bench; no logic of its own.
package qwri_pkg;

    // register file shape
    localparam int NUM_WIPERS = 4;
    localparam int WIPER_W = 8;
    localparam int PTR_W = 2;
    localparam logic [7:0] WIPER_RESET = 8'h80;

    // register address byte values
    localparam logic [7:0] ADDR_WIPER_POSITION_0 = 8'h00;
    localparam logic [7:0] ADDR_WIPER_POSITION_1 = 8'h01;
    localparam logic [7:0] ADDR_WIPER_POSITION_2 = 8'h02;
    localparam logic [7:0] ADDR_WIPER_POSITION_3 = 8'h03;

    // identification byte layout
    localparam logic [3:0] ID_PREFIX = 4'h5;
    localparam int ID_PREFIX_LSB = 4;
    localparam int ID_SEL_LSB = 1;
    localparam int ID_RW_BIT = 0;
    localparam logic RW_READ = 1'b1;

    // bit counting on the serial link
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;
    localparam logic [7:0] TX_IDLE = 8'hff;

    // three device-select straps
    typedef struct packed {
        logic device_select_bit_two;
        logic device_select_bit_one;
        logic device_select_bit_zero;
    } qwri_dev_sel_t;

    // write request carried from the link domain to the system domain
    typedef struct packed {
        logic [PTR_W-1:0] addr;
        logic [WIPER_W-1:0] data;
    } qwri_wr_req_t;

    // all four wiper positions, index 0 in the low byte
    typedef logic [NUM_WIPERS-1:0][WIPER_W-1:0] qwri_wiper_bank_t;

    // link state machine, gray steps along id -> ack -> addr -> data
    typedef enum logic [3:0] {
        st_idle = 4'h0,
        st_id = 4'h1,
        st_ack = 4'h3,
        st_addr = 4'h2,
        st_wdata = 4'h6,
        st_wait = 4'h4,
        st_tx = 4'h7,
        st_tx_ack = 4'h5
    } qwri_state_t;

endpackage

// *** tb/qwri_bus_master.sv ***
// qwri_bus_master: behavioural serial-bus master that drives the slave's bus pins.
// assumes: the bench ands sda_drive with the slave's pull-down to form the pulled-up wire.
`timescale 1ns/100ps
module qwri_bus_master #(
    // a short quarter keeps the run small; the slave needs only ~200 ns per phase
    parameter int QUARTER_NS = 300
) (
    output logic scl,
    output logic sda_drive,
    input wire logic sda
);
    // both lines idle high; only this master ever moves scl
    initial begin
        scl = 1'b1;
        sda_drive = 1'b1;
    end

    // one bit out: data set while scl is low, held across the high phase
    task automatic bit_out(input logic b);
        sda_drive <= b;
        #(QUARTER_NS) scl <= 1'b1;
        #(2 * QUARTER_NS) scl <= 1'b0;
        #(QUARTER_NS);
    endtask

    // one bit in: sample in mid high phase, the slave's answer has long settled
    task automatic bit_in(output logic b);
        sda_drive <= 1'b1;
        #(QUARTER_NS) scl <= 1'b1;
        #(QUARTER_NS) b = sda;
        #(QUARTER_NS) scl <= 1'b0;
        #(QUARTER_NS);
    endtask

    // start and repeated start: sda falls while scl is high
    task automatic start();
        sda_drive <= 1'b1;
        #(QUARTER_NS) scl <= 1'b1;
        #(2 * QUARTER_NS) sda_drive <= 1'b0;
        #(2 * QUARTER_NS) scl <= 1'b0;
        #(QUARTER_NS);
    endtask

    // stop, then a bus-free gap longer than the minimum
    task automatic stop();
        sda_drive <= 1'b0;
        #(QUARTER_NS) scl <= 1'b1;
        #(2 * QUARTER_NS) sda_drive <= 1'b1;
        #(4 * QUARTER_NS);
    endtask

    // byte out msb first, then the ninth clock for the slave's ack
    task automatic send_byte(input logic [7:0] d, output logic acked);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        bit_in(b);
        acked = ~b;
    endtask

    // byte in msb first; ack asks for more, nack ends the read
    task automatic recv_byte(output logic [7:0] d, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_in(d[i]);
        end
        bit_out(~ack);
    endtask
endmodule

// *** tb/test_quad_wiper_register_i2c_slave.sv ***
// test_quad_wiper_register_i2c_slave: directed bench for the quad wiper serial slave.
// assumes: qwri_pkg compiled first; the slave body carries its own chk_ assertions.
`timescale 1ns/100ps
module test_quad_wiper_register_i2c_slave;
    import qwri_pkg::*;
    localparam logic [2:0] STRAP = 3'h5;
    logic clk, link_clk, arst_n, scl, sda_m, sda_in, sda_out, sda_drive_n, ack;
    qwri_dev_sel_t dev_select;
    qwri_wiper_bank_t wiper_tap;
    logic [7:0] shadow [NUM_WIPERS];
    int n_mismatch, check_count;

    // clocks of unrelated phase
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #7.3;
        forever #15 link_clk = ~link_clk;
    end

    // pulled-up wire: low when either party pulls it
    assign sda_in = sda_m & (sda_drive_n | sda_out);

    qwri_slave uut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk), .scl(scl),
        .sda_in(sda_in), .dev_select(dev_select), .sda_out(sda_out),
        .sda_drive_n(sda_drive_n), .wiper_tap(wiper_tap));
    qwri_bus_master m (.scl(scl), .sda_drive(sda_m), .sda(sda_in));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // bounded wait for the bank to match the shadow copy, then compare
    task automatic check_bank();
        qwri_wiper_bank_t exp;
        int k;
        for (int i = 0; i < NUM_WIPERS; i++) begin
            exp[i] = shadow[i];
        end
        for (k = 0; k < 300 && wiper_tap !== exp; k++) begin
            @(posedge clk);
        end
        check("wiper_tap", wiper_tap, exp);
        if (k == 300) begin
            final_report();
        end
    endtask

    // reset pulse, 5 cycles low, then room for the link side to wake
    task automatic pulse_reset();
        @(posedge clk) arst_n <= 1'b0;
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (30) @(posedge clk);
        for (int i = 0; i < NUM_WIPERS; i++) begin
            shadow[i] = WIPER_RESET;
        end
    endtask

    task automatic do_write(input logic [7:0] a, input logic [7:0] d);
        m.start();
        m.send_byte({ID_PREFIX, STRAP, 1'b0}, ack);
        check("id ack", 32'(ack), 32'h1);
        m.send_byte(a, ack);
        check("addr ack", 32'(ack), 32'(a < 8'h04));
        // data goes out even after a refused address, to prove it is dropped
        m.send_byte(d, ack);
        check("data ack", 32'(ack), 32'(a < 8'h04));
        if (a < 8'h04) begin
            shadow[a[1:0]] = d;
        end
        m.stop();
        check_bank();
    endtask

    task automatic do_read(input logic [7:0] a, input int n);
        logic [7:0] d;
        m.start();
        m.send_byte({ID_PREFIX, STRAP, 1'b0}, ack);
        m.send_byte(a, ack);
        check("read addr ack", 32'(ack), 32'h1);
        m.start();
        m.send_byte({ID_PREFIX, STRAP, RW_READ}, ack);
        check("read id ack", 32'(ack), 32'h1);
        for (int i = 0; i < n; i++) begin
            m.recv_byte(d, i < n - 1);
            check("read data", 32'(d), 32'(shadow[(a + i) % 4]));
        end
        m.stop();
    endtask

    // reset values on the taps and by a wrapping read
    task automatic t_reset_values();
        check("reset bank", wiper_tap, 32'h80808080);
        do_read(8'h00, 5);
    endtask

    // each register written alone, ends of the code range included
    task automatic t_write_each();
        logic [7:0] vals [4] = '{8'h00, 8'hff, 8'h12, 8'h6b};
        for (int i = 0; i < NUM_WIPERS; i++) begin
            do_write(8'(i), vals[i]);
        end
        do_read(8'h02, 5);
        do_read(8'h03, 2);
    endtask

    // foreign prefix or select bits: no ack, nothing changes
    task automatic t_bad_id();
        logic [7:0] ids [4] = '{{4'h4, STRAP, 1'b0}, {ID_PREFIX, STRAP ^ 3'h1, 1'b0},
            {ID_PREFIX, STRAP ^ 3'h2, 1'b0}, {ID_PREFIX, STRAP ^ 3'h4, 1'b0}};
        foreach (ids[i]) begin
            m.start();
            m.send_byte(ids[i], ack);
            check("foreign id ack", 32'(ack), 32'h0);
            m.send_byte(8'h01, ack);
            m.send_byte(8'h44, ack);
            m.stop();
            check_bank();
        end
    endtask

    // addresses beyond the last register are refused
    task automatic t_bad_addr();
        do_write(8'h04, 8'h33);
        do_write(8'hff, 8'h34);
    endtask

    // a second data byte in one write is not taken
    task automatic t_extra_byte();
        m.start();
        m.send_byte({ID_PREFIX, STRAP, 1'b0}, ack);
        m.send_byte(8'h01, ack);
        m.send_byte(8'h77, ack);
        check("first data ack", 32'(ack), 32'h1);
        m.send_byte(8'h99, ack);
        check("extra data ack", 32'(ack), 32'h0);
        m.stop();
        shadow[1] = 8'h77;
        check_bank();
    endtask

    // reset in mid-run brings every tap back to mid-scale
    task automatic t_rereset();
        pulse_reset();
        check_bank();
        do_read(8'h01, 2);
    endtask

    initial begin
        arst_n = 1'b0;
        dev_select = qwri_dev_sel_t'(STRAP);
        n_mismatch = 0;
        check_count = 0;
        pulse_reset();
        t_reset_values();
        t_write_each();
        t_bad_id();
        t_bad_addr();
        t_extra_byte();
        t_rereset();
        final_report();
    end
endmodule
